// File: rtl/host_serial_packet_framer.sv
// serial packet framer: uart, packet check, packet send
`timescale 1ns/10ps
`include "pkt_framer_cfg.svh"
module host_serial_packet_framer
	import pkt_framer_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       resetn,
	// serial pins
	input  wire logic       rxd,
	output logic            txd,
	// received packet out to the command engine
	output logic            cmdValid,
	input  wire logic       cmdReady,
	output logic [5:0]      cmdCode,
	output logic [4:0]      cmdLen,
	output logic [7:0]      cmdByte,
	output logic [4:0]      cmdIdx,
	output logic            cmdLast,
	// answer or report in from the command engine
	input  wire logic       ansValid,
	output logic            ansReady,
	input  wire logic [1:0] ansClass,
	input  wire logic [5:0] ansCode,
	input  wire logic [4:0] ansLen,
	input  wire logic [7:0] ansPayload [0:21],
	// status
	output logic            answerLate
);
	// ========================================================
	// reset release
	logic rstSync1_r;
	logic rstn_r;
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstSync1_r <= 1'b0;
			rstn_r     <= 1'b0;
		end
		else
		begin
			rstSync1_r <= 1'b1;
			rstn_r     <= rstSync1_r;
		end
	end

	// ========================================================
	// crc step, used by receiver and transmitter
	function automatic logic [15:0] crcStep(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] x;
		x = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
			x = x[0] ? ((x >> 1) ^ `CRC_POLY) : (x >> 1);
		return x;
	endfunction

	localparam logic [15:0] BIT_CNT  = 16'(`BIT_CYCLES);
	localparam logic [15:0] HALF_CNT = 16'(`BIT_CYCLES / 2);

	// ========================================================
	// uart receiver, 8N1
	logic [15:0] rxTmr_r;
	logic [3:0]  rxBit_r;
	logic [7:0]  rxShift_r;
	logic        rxBusy_r;
	logic        rxStrobe_r;
	wire         rxTick = rxBusy_r && (rxTmr_r == 16'h0000);
	always_ff @(posedge clk or negedge rstn_r)
	begin
		if (!rstn_r)
		begin
			rxTmr_r    <= 16'h0000;
			rxBit_r    <= 4'h0;
			rxShift_r  <= 8'h00;
			rxBusy_r   <= 1'b0;
			rxStrobe_r <= 1'b0;
		end
		else
		begin
			rxStrobe_r <= 1'b0;
			if (!rxBusy_r)
			begin
				if (!rxd)
				begin
					rxBusy_r <= 1'b1;
					rxTmr_r  <= HALF_CNT;
					rxBit_r  <= 4'h0;
				end
			end
			else if (!rxTick)
				rxTmr_r <= rxTmr_r - 16'h0001;
			else
			begin
				rxTmr_r <= BIT_CNT - 16'h0001;
				rxBit_r <= rxBit_r + 4'h1;
				if (rxBit_r == 4'h0 && rxd)
					rxBusy_r <= 1'b0; // false start
				else if (rxBit_r == 4'h9)
				begin
					rxBusy_r   <= 1'b0;
					rxStrobe_r <= rxd; // framing error drops byte
				end
				else if (rxBit_r != 4'h0)
					rxShift_r <= {rxd, rxShift_r[7:1]}; // lsb first
			end
		end
	end

	// ========================================================
	// packet receiver; payload held until the check value passes
	rxState_t    rxSt_r;
	logic [5:0]  rxCode_r;
	logic [1:0]  rxCls_r;
	logic [4:0]  rxLen_r;
	logic [4:0]  rxCnt_r;
	logic [15:0] rxCrc_r;
	logic [7:0]  rxLo_r;
	logic [7:0]  rxMem_r [0:21];
	logic        pktGood_r;
	logic        rxLost_r;
	wire  [15:0] rxCrcNxt = crcStep(rxCrc_r, rxShift_r);
	wire         lenOk = rxShift_r <= `MAX_PAYLOAD;
	wire         crcOk = {rxShift_r, rxLo_r} == ~rxCrc_r;
	logic        bufBusy;
	always_ff @(posedge clk or negedge rstn_r)
	begin
		if (!rstn_r)
		begin
			rxSt_r    <= RX_TYPE;
			rxCode_r  <= 6'h00;
			rxCls_r   <= 2'h0;
			rxLen_r   <= 5'h00;
			rxCnt_r   <= 5'h00;
			rxCrc_r   <= `CRC_INIT;
			rxLo_r    <= 8'h00;
			pktGood_r <= 1'b0;
			rxLost_r  <= 1'b0;
		end
		else
		begin
			pktGood_r <= 1'b0;
			if (rxStrobe_r)
			begin
				rxCrc_r <= rxCrcNxt;
				unique case (rxSt_r)
				RX_TYPE:
				begin
					rxCls_r  <= rxShift_r[7:6];
					rxCode_r <= rxShift_r[5:0];
					rxSt_r   <= RX_LEN;
					rxLost_r <= 1'b0; // fresh packet
				end
				RX_LEN:
				begin
					rxLen_r <= rxShift_r[4:0];
					rxCnt_r <= 5'h00;
					if (!lenOk)
					begin
						rxSt_r  <= RX_TYPE; // discard, hunt
						rxCrc_r <= `CRC_INIT;
					end
					else if (rxShift_r == 8'h00)
						rxSt_r <= RX_CRCLO;
					else
						rxSt_r <= RX_DATA;
				end
				RX_DATA:
				begin
					rxCnt_r <= rxCnt_r + 5'h01;
					if (bufBusy)
						rxLost_r <= 1'b1; // byte not stored
					if (rxCnt_r == rxLen_r - 5'h01)
						rxSt_r <= RX_CRCLO;
				end
				RX_CRCLO:
				begin
					rxLo_r  <= rxShift_r;
					rxCrc_r <= rxCrc_r;
					rxSt_r  <= RX_CRCHI;
				end
				RX_CRCHI:
				begin
					rxCrc_r <= `CRC_INIT;
					rxSt_r  <= RX_TYPE;
					// bad crc or busy buffer drops the packet
					// a byte skipped while draining leaves stale payload
					pktGood_r <= crcOk && !bufBusy && !rxLost_r;
				end
				endcase
			end
		end
	end

	// payload store, only written while the buffer is free
	always_ff @(posedge clk)
	begin
		if (rxStrobe_r && rxSt_r == RX_DATA && !bufBusy)
			rxMem_r[rxCnt_r] <= rxShift_r;
	end

	// ========================================================
	// two-entry byte buffer toward the command engine
	logic [7:0] fbData_r [0:1];
	logic [4:0] fbIdx_r  [0:1];
	logic [1:0] fbLast_r;
	logic       fbWp_r;
	logic       fbRp_r;
	logic [1:0] fbCnt_r;
	logic       drain_r;
	logic [4:0] drIdx_r;
	logic [4:0] drLen_r;
	wire        fbFull  = fbCnt_r == 2'h2;
	wire        fbEmpty = fbCnt_r == 2'h0;
	wire        fbPush  = drain_r && !fbFull;
	wire        fbPop   = !fbEmpty && cmdReady;
	wire        drLast  = (drLen_r == 5'h00) || (drIdx_r == drLen_r - 5'h01);
	// a command packet is forwarded; a non-command class is discarded
	assign bufBusy = drain_r || !fbEmpty;
	always_ff @(posedge clk or negedge rstn_r)
	begin
		if (!rstn_r)
		begin
			fbWp_r   <= 1'b0;
			fbRp_r   <= 1'b0;
			fbCnt_r  <= 2'h0;
			fbLast_r <= 2'h0;
			drain_r  <= 1'b0;
			drIdx_r  <= 5'h00;
			drLen_r  <= 5'h00;
			cmdCode  <= 6'h00;
			cmdLen   <= 5'h00;
		end
		else
		begin
			if (pktGood_r && rxCls_r == `CLASS_CMD)
			begin
				drain_r <= 1'b1;
				drIdx_r <= 5'h00;
				drLen_r <= rxLen_r;
				cmdCode <= rxCode_r;
				cmdLen  <= rxLen_r;
			end
			else if (fbPush)
			begin
				drIdx_r <= drIdx_r + 5'h01;
				if (drLast)
					drain_r <= 1'b0;
			end
			if (fbPush)
			begin
				fbLast_r[fbWp_r] <= drLast;
				fbWp_r           <= ~fbWp_r;
			end
			if (fbPop)
				fbRp_r <= ~fbRp_r;
			fbCnt_r <= fbCnt_r + {1'b0, fbPush} - {1'b0, fbPop};
		end
	end

	always_ff @(posedge clk)
	begin
		if (fbPush)
		begin
			fbData_r[fbWp_r] <= rxMem_r[drIdx_r];
			fbIdx_r[fbWp_r]  <= drIdx_r;
		end
	end

	assign cmdValid = !fbEmpty;
	assign cmdByte  = fbData_r[fbRp_r];
	assign cmdIdx   = fbIdx_r[fbRp_r];
	assign cmdLast  = fbLast_r[fbRp_r];

	// ========================================================
	// answer watchdog: flags a command left unanswered for 250 ms
	logic [31:0] ansTmr_r;
	logic        waitAns_r;
	logic [5:0]  pendCode_r;
	wire         ansTake = ansValid && ansReady;
	wire         isAck = ansClass == `CLASS_RESP || ansClass == `CLASS_ERROR;
	always_ff @(posedge clk or negedge rstn_r)
	begin
		if (!rstn_r)
		begin
			ansTmr_r   <= 32'h0;
			waitAns_r  <= 1'b0;
			pendCode_r <= 6'h00;
			answerLate <= 1'b0;
		end
		else
		begin
			if (pktGood_r && rxCls_r == `CLASS_CMD)
			begin
				waitAns_r  <= 1'b1;
				pendCode_r <= rxCode_r;
				ansTmr_r   <= 32'h0;
			end
			else if (ansTake && isAck)
				waitAns_r <= 1'b0;
			else if (waitAns_r)
				ansTmr_r <= ansTmr_r + 32'h1;
			answerLate <= waitAns_r &&
				ansTmr_r >= 32'(`ANSWER_CYCLES - 1);
		end
	end

	// ========================================================
	// packet transmitter and uart sender
	txState_t    txSt_r;
	logic [7:0]  txType_r;
	logic [4:0]  txLen_r;
	logic [4:0]  txIdx_r;
	logic [15:0] txCrc_r;
	logic [7:0]  txPay_r [0:21];
	logic [9:0]  txSh_r;
	logic [3:0]  txBits_r;
	logic [15:0] txTmr_r;
	wire         txIdle = txBits_r == 4'h0;
	wire  [15:0] txFin = ~txCrc_r;
	// acks reuse the pending code; reports pass their own
	wire  [5:0]  outCode = isAck ? pendCode_r : ansCode;
	logic [7:0]  txByte;
	always_comb
	begin
		unique case (txSt_r)
		TX_TYPE:  txByte = txType_r;
		TX_LEN:   txByte = {3'h0, txLen_r};
		TX_DATA:  txByte = txPay_r[txIdx_r]; // raw
		TX_CRCLO: txByte = txFin[7:0];
		TX_CRCHI: txByte = txFin[15:8];
		default:  txByte = 8'h00;
		endcase
	end
	wire txLoad = txSt_r != TX_IDLE && txIdle;
	assign ansReady = txSt_r == TX_IDLE && ansLen <= 5'(`MAX_PAYLOAD);

	always_ff @(posedge clk)
	begin
		if (ansTake)
			txPay_r <= ansPayload;
	end

	always_ff @(posedge clk or negedge rstn_r)
	begin
		if (!rstn_r)
		begin
			txSt_r   <= TX_IDLE;
			txType_r <= 8'h00;
			txLen_r  <= 5'h00;
			txIdx_r  <= 5'h00;
			txCrc_r  <= `CRC_INIT;
			txSh_r   <= 10'h3ff;
			txBits_r <= 4'h0;
			txTmr_r  <= 16'h0000;
			txd      <= 1'b1;
		end
		else
		begin
			if (ansTake)
			begin
				// class 10 report, 11 error, 01 response
				txType_r <= {ansClass, outCode};
				txLen_r  <= ansLen;
				txIdx_r  <= 5'h00;
				txCrc_r  <= `CRC_INIT;
				txSt_r   <= TX_TYPE;
			end
			else if (txLoad)
			begin
				txSh_r   <= {1'b1, txByte, 1'b0};
				txBits_r <= 4'ha;
				txTmr_r  <= BIT_CNT - 16'h0001;
				if (txSt_r != TX_CRCLO && txSt_r != TX_CRCHI)
					txCrc_r <= crcStep(txCrc_r, txByte);
				unique case (txSt_r)
				TX_TYPE:  txSt_r <= TX_LEN;
				TX_LEN:   txSt_r <= (txLen_r == 5'h00) ? TX_CRCLO : TX_DATA;
				TX_DATA:
				begin
					txIdx_r <= txIdx_r + 5'h01;
					if (txIdx_r == txLen_r - 5'h01)
						txSt_r <= TX_CRCLO;
				end
				TX_CRCLO: txSt_r <= TX_CRCHI;
				TX_CRCHI: txSt_r <= TX_IDLE;
				default:  txSt_r <= TX_IDLE;
				endcase
			end
			if (!txIdle)
			begin
				if (txTmr_r == 16'h0000)
				begin
					txTmr_r  <= BIT_CNT - 16'h0001;
					txSh_r   <= {1'b1, txSh_r[9:1]};
					txBits_r <= txBits_r - 4'h1;
				end
				else
					txTmr_r <= txTmr_r - 16'h0001;
			end
			txd <= txIdle ? 1'b1 : txSh_r[0];
		end
	end
endmodule

// File: rtl/pkt_framer_cfg.svh
// constants for the serial packet framer
`ifndef PKT_FRAMER_CFG_SVH
`define PKT_FRAMER_CFG_SVH
`define CLK_HZ        100000000
`define BAUD_RATE     115200
`define BIT_CYCLES    ((`CLK_HZ + `BAUD_RATE / 2) / `BAUD_RATE)
`define MAX_PAYLOAD   8'h16
`define CRC_POLY      16'h8408
`define CRC_INIT      16'hffff
`define CLASS_CMD     2'h0
`define CLASS_RESP    2'h1
`define CLASS_REPORT  2'h2
`define CLASS_ERROR   2'h3
`define ANSWER_MS     250
`define ANSWER_CYCLES (`ANSWER_MS * (`CLK_HZ / 1000))
`endif

// File: rtl/pkt_framer_pkg.sv
// types for the serial packet framer
package pkt_framer_pkg;
	typedef enum logic [2:0] {
		RX_TYPE  = 3'h0,
		RX_LEN   = 3'h1,
		RX_DATA  = 3'h2,
		RX_CRCLO = 3'h3,
		RX_CRCHI = 3'h4
	} rxState_t;
	typedef enum logic [2:0] {
		TX_IDLE  = 3'h0,
		TX_TYPE  = 3'h1,
		TX_LEN   = 3'h2,
		TX_DATA  = 3'h3,
		TX_CRCLO = 3'h4,
		TX_CRCHI = 3'h5
	} txState_t;
endpackage

// File: verification/pkt_framer_monitor.sv
// port checker for the serial packet framer
`timescale 1ns/10ps
module pkt_framer_monitor
(
	// clock and reset
	input wire logic       clk,
	input wire logic       resetn,
	// serial out
	input wire logic       txd,
	// command side
	input wire logic       cmdValid,
	input wire logic       cmdReady,
	input wire logic [5:0] cmdCode,
	input wire logic [4:0] cmdLen,
	input wire logic [7:0] cmdByte,
	input wire logic [4:0] cmdIdx,
	input wire logic       cmdLast,
	// answer side
	input wire logic       ansValid,
	input wire logic       ansReady,
	input wire logic [4:0] ansLen
);
	// ================================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// handshake and held head byte as named steps
	sequence ansTaken;
		ansValid && ansReady;
	endsequence
	sequence headStall;
		cmdValid && !cmdReady;
	endsequence
	chk_tx_start: assert property (ansTaken |-> ##[1:4] !txd)
		else $error("answer did not start a frame");
	chk_busy_hold: assert property (ansTaken |=> !ansReady [*8])
		else $error("answer side ready while sending");
	chk_len_refuse: assert property (ansLen > 5'h16 |-> !ansReady)
		else $error("overlong answer offered ready");
	chk_start_width: assert property ($fell(txd) |-> !txd [*8])
		else $error("start bit too short");
	chk_head_held: assert property (headStall |=> cmdValid
		&& $stable(cmdByte) && $stable(cmdIdx))
		else $error("stalled byte changed or vanished");
	chk_cmd_len: assert property (cmdValid |-> cmdLen <= 5'h16)
		else $error("forwarded count above limit");
	chk_last_flag: assert property (cmdValid && cmdLen != 5'h0
		|-> cmdLast == (cmdIdx == cmdLen - 5'h1))
		else $error("last flag misplaced");
	chk_first_idx: assert property ($rose(cmdValid) |-> cmdIdx == 5'h0)
		else $error("command did not start at index zero");
	chk_code_hold: assert property (cmdValid && !(cmdReady && cmdLast)
		|=> $stable(cmdCode) && $stable(cmdLen))
		else $error("code changed inside a command");
endmodule
bind host_serial_packet_framer pkt_framer_monitor mon_u (.clk(clk),
	.resetn(resetn), .txd(txd), .cmdValid(cmdValid), .cmdReady(cmdReady),
	.cmdCode(cmdCode), .cmdLen(cmdLen), .cmdByte(cmdByte), .cmdIdx(cmdIdx),
	.cmdLast(cmdLast), .ansValid(ansValid), .ansReady(ansReady),
	.ansLen(ansLen));

// File: verification/host_link_model.sv
// host side serial model: character sender and catcher
`timescale 1ns/10ps
`include "pkt_framer_cfg.svh"
module host_link_model
(
	// clock
	input  wire logic clk,
	// serial lines, named from the host side
	output logic      toDev,
	input  wire logic fromDev
);
	logic [7:0] rxQ [$];
	int         badStops;
	// ================================================================
	// 8N1 sender, lsb first; line rests high (pull-up level) when idle
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(negedge clk) toDev = frame[i];
			repeat (`BIT_CYCLES - 1) @(negedge clk);
		end
	endtask
	// catcher samples mid-bit; bad stop bits are counted, not kept
	initial
	begin : catcher
		logic [7:0] b;
		toDev = 1'b1;
		badStops = 0;
		forever
		begin
			@(negedge fromDev);
			repeat (`BIT_CYCLES / 2) @(posedge clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (`BIT_CYCLES) @(posedge clk);
				b[i] = fromDev;
			end
			repeat (`BIT_CYCLES) @(posedge clk);
			if (fromDev === 1'b1)
				rxQ.push_back(b);
			else
				badStops++; // drop, hunt the next start
		end
	end
endmodule

// File: verification/host_serial_packet_framer_tb_top.sv
// testbench for the serial packet framer
`timescale 1ns/10ps
module host_serial_packet_framer_tb_top;
	import pkt_framer_pkg::*;
	logic        clk, resetn, rxd, txd, cmdValid, cmdReady, cmdLast;
	logic        ansValid, ansReady, answerLate;
	logic [1:0]  ansClass;
	logic [5:0]  cmdCode, ansCode;
	logic [4:0]  cmdLen, cmdIdx, ansLen;
	logic [7:0]  cmdByte;
	logic [7:0]  ansPayload [0:21];
	int          fails, checked, n;
	int unsigned seed;
	int          code, pay, rc, pkt[$], rep[$], bad[$];
	// ================================================================
	// design, far side and clock
	host_serial_packet_framer dut_u (.clk(clk), .resetn(resetn),
		.rxd(rxd), .txd(txd), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.cmdCode(cmdCode), .cmdLen(cmdLen), .cmdByte(cmdByte),
		.cmdIdx(cmdIdx), .cmdLast(cmdLast), .ansValid(ansValid),
		.ansReady(ansReady), .ansClass(ansClass), .ansCode(ansCode),
		.ansLen(ansLen), .ansPayload(ansPayload), .answerLate(answerLate));
	host_link_model host_u (.clk(clk), .toDev(rxd), .fromDev(txd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ================================================================
	// helpers: random, crc, compare, finish
	function automatic int nextRand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed & 32'h7fffffff);
	endfunction
	// reflected crc over type, count, payload; low byte goes first
	task automatic addCrc(ref int q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c ^= 16'(q[i] & 8'hff);
			for (int b = 0; b < 8; b++)
				c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
		end
		c = ~c;
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
	endtask
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		checked++;
		if (got !== exp)
		begin
			$display("unexpected at %0t: %s got %h want %h", $time, what,
				got, exp);
			fails++;
		end
	endtask
	task automatic wrap_up();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stuck(input string what);
		$display("unexpected at %0t: wait for %s ran out", $time, what);
		fails++;
		wrap_up();
	endtask
	// answer request held until the edge that takes it
	task automatic sendAnswer(input logic [1:0] cls, input logic [5:0] cd,
		input logic [4:0] len, input logic [7:0] b0);
		@(negedge clk);
		ansValid = 1'b1;
		ansClass = cls;
		ansCode = cd;
		ansLen = len;
		ansPayload[0] = b0;
		for (n = 0; n < 100; n++)
		begin
			@(posedge clk);
			if (ansReady === 1'b1)
				break;
		end
		if (n == 100)
			stuck("answer ready");
		@(negedge clk) ansValid = 1'b0;
	endtask
	// serial bytes from the device, compared in order with the expected frame
	task automatic cmpWire(ref int q[$], input string what);
		for (n = 0; n < 60000 && host_u.rxQ.size() < q.size(); n++)
			@(posedge clk);
		if (n == 60000)
			stuck(what);
		foreach (q[i])
			cmp(host_u.rxQ.pop_front(), q[i][7:0], what);
	endtask
	// ================================================================
	// main sequence
	initial
	begin
		seed = 11;
		fails = 0;
		checked = 0;
		resetn = 1'b0;
		cmdReady = 1'b0;
		ansValid = 1'b0;
		ansClass = 2'h0;
		ansCode = 6'h00;
		ansLen = 5'h00;
		foreach (ansPayload[i])
			ansPayload[i] = 8'h00;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		repeat (4) @(negedge clk);
		// command in while a report goes out; engine stalls the head
		code = nextRand() % 64;
		pay = nextRand() % 256;
		rc = nextRand() % 64;
		pkt = {code, 1, pay};
		addCrc(pkt);
		rep = {8'h80 | rc, 0};
		addCrc(rep);
		fork
			foreach (pkt[i])
				host_u.send_byte(pkt[i][7:0]);
			sendAnswer(2'h2, rc[5:0], 5'h00, 8'h00);
		join
		for (n = 0; n < 2000 && cmdValid !== 1'b1; n++)
			@(negedge clk);
		if (n == 2000)
			stuck("command");
		repeat (5) @(negedge clk);
		cmp(cmdCode, code[7:0], "code");
		cmp(cmdLen, 8'h01, "count");
		cmp(cmdByte, pay[7:0], "payload");
		cmp(cmdIdx, 8'h00, "index");
		cmp(cmdLast, 8'h01, "last");
		cmdReady = 1'b1;
		@(negedge clk) cmdReady = 1'b0;
		cmp(cmdValid, 8'h00, "drained");
		cmp(answerLate, 8'h00, "late flag");
		cmpWire(rep, "report");
		$display("test 1 done");
		// response must copy the command code, not the offered one
		pay = nextRand() % 256;
		pkt = {8'h40 | code, 1, pay};
		addCrc(pkt);
		// meanwhile an overlong header and a bad check value arrive
		bad = {nextRand() % 64, 0};
		addCrc(bad);
		bad[2] = bad[2] ^ 1;
		bad = {rc, 23, bad};
		fork
			begin
				sendAnswer(2'h1, ~code[5:0], 5'h01, pay[7:0]);
				cmpWire(pkt, "response");
			end
			foreach (bad[i])
				host_u.send_byte(bad[i][7:0]);
		join
		cmp(cmdValid, 8'h00, "discarded");
		cmp(answerLate, 8'h00, "late flag");
		cmp(host_u.badStops, 8'h00, "stop bits");
		$display("test 2 done");
		wrap_up();
	end
endmodule
